// >>> logic/boot_mode_lock_control.sv
`timescale 1ns/1ps
// Contract
// - Loader runs and takes commands only in ROM boot; flash boot refuses all.
// - Once flash boot is locked, further boot mode changes are ignored.
// - Locked in flash boot, loader flash read and write commands are blocked.
// - ROM hiding makes ROM inaccessible and flash read-only.
// - Exactly one boot domain, ROM or flash, is held at any time.
// - Test to normal mode is one-way; test mode never returns.
// - Any access to an invalid address raises an indication.
module bmlc_boot_mode_lock_control
  import bmlc_pkg::*;
#(
  parameter int               AW       = ADDR_W,
  parameter logic [ADDR_W-1:0] RomBase  = ROM_BASE,
  parameter logic [ADDR_W-1:0] RomLim   = ROM_LIMIT,
  parameter logic [ADDR_W-1:0] FlBase   = FLASH_BASE,
  parameter logic [ADDR_W-1:0] FlLim    = FLASH_LIMIT,
  parameter logic [ADDR_W-1:0] RamBase  = RAM_BASE,
  parameter logic [ADDR_W-1:0] RamLim   = RAM_LIMIT
) (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  // Non-volatile image restore and store
  input  wire logic            nvValid,
  input  wire bmlc_nv_t        nvImage,
  output logic                 nvWriteEn,
  output bmlc_nv_t             nvWriteData,
  // Mode change requests
  input  wire logic            setFlashBoot,
  input  wire logic            setRomBoot,
  input  wire logic            lockReq,
  input  wire logic            enterNormalReq,
  input  wire logic            romHideReq,
  // Loader command port
  input  wire logic            cmdValid,
  input  wire bmlc_cmd_t       cmdKind,
  output logic                 cmdAccept,
  output logic                 cmdReject,
  // Address check port
  input  wire logic            accValid,
  input  wire logic            accWrite,
  input  wire logic [AW-1:0]   accAddr,
  input  wire logic            invalidClr,
  output logic                 invalidPulse,
  output logic                 invalidFlag,
  // Status
  output logic                 ready,
  output logic                 romBootSel,
  output logic                 flashBootSel,
  output logic                 modeLocked,
  output logic                 loaderEnable,
  output logic                 testModeEn,
  output logic                 normalMode,
  output logic                 romAccessible,
  output logic                 flashWritable
);

  // ----------------------------------------
  // State and image
  // ----------------------------------------
  bmlc_state_t state_q;
  bmlc_nv_t    img_q;
  bmlc_nv_t    img_d;
  logic        run;
  logic        inRom;
  logic        inFlash;
  logic        inRam;
  logic        badAcc;
  logic        cmdOk;

  assign run = (state_q == ST_RUN);

  // Next image from requests, only while running
  always_comb begin
    img_d = img_q;
    if (run) begin
      if (!img_q.modeLock && (setFlashBoot != setRomBoot)) begin
        img_d.flashBoot = setFlashBoot;
      end
      if (lockReq && img_q.flashBoot) begin
        img_d.modeLock = 1'b1;
      end
      if (enterNormalReq) begin
        img_d.normalMode = 1'b1;
      end
      if (romHideReq) begin
        img_d.romHidden = 1'b1;
      end
    end
  end

  // Restore once after release, then run
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_LOAD;
    end else begin
      case (state_q)
        ST_LOAD: if (nvValid) begin
          state_q <= ST_RUN;
        end
        ST_RUN:  state_q <= ST_RUN;
        default: state_q <= ST_LOAD;
      endcase
    end
  end

  // Image register; sticky bits only ever set
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      img_q <= NV_RESET;
    end else if (!run && nvValid) begin
      img_q <= nvImage;
    end else begin
      img_q <= img_d;
    end
  end

  // Store every change of the image
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nvWriteEn   <= 1'b0;
      nvWriteData <= NV_RESET;
    end else begin
      nvWriteEn   <= run && (img_d != img_q);
      nvWriteData <= img_d;
    end
  end

  // ----------------------------------------
  // Loader command gate
  // ----------------------------------------
  always_comb begin
    cmdOk = run && !img_q.flashBoot;
    if (cmdKind == CMD_FLASH_WRITE && img_q.romHidden) begin
      cmdOk = 1'b0;
    end
    if (img_q.flashBoot && img_q.modeLock && cmdKind != CMD_OTHER) begin
      cmdOk = 1'b0;
    end
  end

  // Registered accept or refuse, one cycle after the command
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmdAccept <= 1'b0;
      cmdReject <= 1'b0;
    end else begin
      cmdAccept <= cmdValid && cmdOk;
      cmdReject <= cmdValid && !cmdOk;
    end
  end

  // ----------------------------------------
  // Address check
  // ----------------------------------------
  assign inRom   = (accAddr >= RomBase) && (accAddr <= RomLim);
  assign inFlash = (accAddr >= FlBase) && (accAddr <= FlLim);
  assign inRam   = (accAddr >= RamBase) && (accAddr <= RamLim);
  assign badAcc  = accValid && !((inRom && !img_q.romHidden)
                   || (inFlash && !(accWrite && img_q.romHidden)) || inRam);

  // Pulse and sticky flag; a new event beats the clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      invalidPulse <= 1'b0;
      invalidFlag  <= 1'b0;
    end else begin
      invalidPulse <= badAcc;
      if (badAcc) begin
        invalidFlag <= 1'b1;
      end else if (invalidClr) begin
        invalidFlag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  assign ready         = run;
  assign flashBootSel  = img_q.flashBoot;
  assign romBootSel    = !img_q.flashBoot;
  assign modeLocked    = img_q.modeLock;
  assign loaderEnable  = run && !img_q.flashBoot;
  assign normalMode    = img_q.normalMode;
  assign testModeEn    = run && !img_q.normalMode;
  assign romAccessible = !img_q.romHidden;
  assign flashWritable = !img_q.romHidden;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_flash_refuses: assert property (cmdValid && run && img_q.flashBoot |=> cmdReject && !cmdAccept)
    else $error("loader command taken in flash boot");
  a_lock_holds_mode: assert property (run && img_q.modeLock |=> $stable(img_q.flashBoot))
    else $error("boot mode changed while locked");
  a_locked_blocks_rw: assert property (cmdValid && cmdKind != CMD_OTHER && flashBootSel && modeLocked
                                       |=> !cmdAccept)
    else $error("flash command passed while locked");
  a_hidden_rom_trap: assert property (accValid && inRom && !inFlash && !inRam && !romAccessible
                                      |=> invalidPulse && invalidFlag)
    else $error("hidden ROM access not trapped");
  a_one_domain: assert property (romBootSel != flashBootSel && !(loaderEnable && flashBootSel))
    else $error("boot domains not exclusive");
  a_hidden_no_write: assert property (cmdValid && cmdKind == CMD_FLASH_WRITE && !flashWritable |=> cmdReject)
    else $error("flash write taken while read-only");
  a_normal_sticky: assert property (run && normalMode |=> normalMode && !testModeEn)
    else $error("test mode re-entered");
  a_invalid_flag: assert property (badAcc && invalidClr |=> invalidFlag)
    else $error("invalid access flag lost");
  a_nv_restore: assert property (!run && nvValid |=> run && img_q == $past(nvImage))
    else $error("stored image not restored");
  a_lock_needs_flash: assert property ($rose(img_q.modeLock) && run |-> img_q.flashBoot)
    else $error("lock taken outside flash boot");

  c_rom_cmd: cover property (cmdValid && loaderEnable ##1 cmdAccept);
  c_lock_seq: cover property (setFlashBoot && run ##[1:8] lockReq ##1 modeLocked);
  c_normal: cover property (enterNormalReq && testModeEn ##1 normalMode);
  c_bad_addr: cover property (invalidPulse ##1 invalidClr);

endmodule

// >>> logic/bmlc_pkg.sv
package bmlc_pkg;

  // ----------------------------------------
  // Persistent protection image
  // ----------------------------------------
  typedef struct packed {
    logic romHidden;
    logic normalMode;
    logic modeLock;
    logic flashBoot;
  } bmlc_nv_t;

  // Safe value held until the stored image is restored
  localparam bmlc_nv_t NV_RESET = 4'h0;

  // ----------------------------------------
  // Loader command kinds and control states
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMD_FLASH_READ  = 2'h0,
    CMD_FLASH_WRITE = 2'h1,
    CMD_OTHER       = 2'h2
  } bmlc_cmd_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } bmlc_state_t;

  // ----------------------------------------
  // Default address map
  // ----------------------------------------
  localparam int          ADDR_W     = 16;
  localparam logic [15:0] ROM_BASE   = 16'h0000;
  localparam logic [15:0] ROM_LIMIT  = 16'h1FFF;
  localparam logic [15:0] FLASH_BASE = 16'h4000;
  localparam logic [15:0] FLASH_LIMIT = 16'hBFFF;
  localparam logic [15:0] RAM_BASE   = 16'hC000;
  localparam logic [15:0] RAM_LIMIT  = 16'hCFFF;

endpackage

// >>> testbench/bmlc_nv_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Non-volatile image store beside the block
// ----------------------------------------
module bmlc_nv_model
  import bmlc_pkg::*;
(
  // Clock and reset
  input  wire logic     core_clk,
  input  wire logic     reset_n,
  // Image store and restore
  input  wire logic     nvWriteEn,
  input  wire bmlc_nv_t nvWriteData,
  output logic          nvValid,
  output bmlc_nv_t      nvImage
);
  bmlc_nv_t memQ = NV_RESET;
  // Stored image is kept across every reset
  always @(posedge core_clk)
    if (nvWriteEn)
      memQ <= nvWriteData;
  // Image valid one cycle after reset release
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      nvValid <= 1'h0;
    else
      nvValid <= 1'h1;
  // Junk on the lines until valid
  assign nvImage = nvValid ? memQ : ~memQ;
endmodule

// >>> testbench/bmlc_boot_mode_lock_control_tb.sv
`timescale 1ns/1ps
module bmlc_boot_mode_lock_control_tb
  import bmlc_pkg::*;
;
  logic core_clk = 1'h0, reset_n = 1'h0, nvValid, nvWriteEn, ready, invalidPulse, invalidFlag;
  logic setFlashBoot, setRomBoot, lockReq, enterNormalReq, romHideReq, cmdValid, cmdAccept, cmdReject;
  logic accValid, accWrite, invalidClr, romBootSel, flashBootSel, modeLocked, loaderEnable;
  logic testModeEn, normalMode, romAccessible, flashWritable;
  logic [15:0] accAddr;
  logic [7:0]  st;
  bmlc_nv_t    nvImage, nvWriteData;
  bmlc_cmd_t   cmdKind;
  int          error_cnt = 0, tests_run = 0, cycles = 0;
  logic [16:0] tbl [10] = '{17'h00000, 17'h01FFF, 17'h12000, 17'h13FFF, 17'h04000,
                            17'h0BFFF, 17'h0C000, 17'h0CFFF, 17'h1D000, 17'h1FFFF};
  // Clock and status vector
  always #12.5 core_clk = ~core_clk;
  assign st = {romBootSel, flashBootSel, modeLocked, loaderEnable, testModeEn, normalMode,
               romAccessible, flashWritable};
  bmlc_boot_mode_lock_control i_dut (.core_clk, .reset_n, .nvValid, .nvImage, .nvWriteEn, .nvWriteData,
    .setFlashBoot, .setRomBoot, .lockReq, .enterNormalReq, .romHideReq, .cmdValid, .cmdKind, .cmdAccept,
    .cmdReject, .accValid, .accWrite, .accAddr, .invalidClr, .invalidPulse, .invalidFlag, .ready, .romBootSel,
    .flashBootSel, .modeLocked, .loaderEnable, .testModeEn, .normalMode, .romAccessible, .flashWritable);
  bmlc_nv_model i_nv (.core_clk, .reset_n, .nvWriteEn, .nvWriteData, .nvValid, .nvImage);
  // ----------------------------------------
  // Check, report and access tasks
  // ----------------------------------------
  task test_done;
    $display("errors %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Reset, then wait for the image restore
  task rst(input logic [7:0] exp);
    @(negedge core_clk);
    reset_n = 1'h0;
    repeat (8) @(negedge core_clk);
    chk({ready, loaderEnable, testModeEn}, 16'h0000);
    reset_n = 1'h1;
    for (int i = 0; i < 20 && ready !== 1'h1; i++) @(negedge core_clk);
    chk(st, exp);
  endtask
  // One-cycle mode request {flash, rom, lock, normal, hide}
  task req(input logic [4:0] r, input logic [7:0] exp, input logic w);
    @(negedge core_clk);
    {setFlashBoot, setRomBoot, lockReq, enterNormalReq, romHideReq} = r;
    @(negedge core_clk);
    {setFlashBoot, setRomBoot, lockReq, enterNormalReq, romHideReq} = 5'h00;
    chk(nvWriteEn, w);
    chk(st, exp);
  endtask
  task cmd(input bmlc_cmd_t k, input logic [1:0] exp);
    @(negedge core_clk);
    cmdValid = 1'h1;
    cmdKind = k;
    @(negedge core_clk);
    cmdValid = 1'h0;
    chk({cmdAccept, cmdReject}, exp);
  endtask
  task acc(input logic [15:0] a, input logic w, input logic bad);
    @(negedge core_clk);
    {accValid, accWrite, accAddr} = {1'h1, w, a};
    @(negedge core_clk);
    accValid = 1'h0;
    chk(invalidPulse, bad);
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {setFlashBoot, setRomBoot, lockReq, enterNormalReq, romHideReq} = 5'h00;
    {cmdValid, accValid, accWrite, invalidClr, accAddr} = '0;
    cmdKind = CMD_OTHER;
    rst(8'h9B);
    for (int k = 0; k < 3; k++) cmd(bmlc_cmd_t'(k), 2'h2);
    for (int i = 0; i < 10; i++) acc(tbl[i][15:0], 1'h0, tbl[i][16]);
    chk(invalidFlag, 1'h1);
    @(negedge core_clk);
    invalidClr = 1'h1;
    @(negedge core_clk);
    invalidClr = 1'h0;
    chk(invalidFlag, 1'h0);
    // Bad access and clear in one cycle: the set wins
    @(negedge core_clk);
    invalidClr = 1'h1;
    acc(16'h2000, 1'h0, 1'h1);
    invalidClr = 1'h0;
    chk(invalidFlag, 1'h1);
    acc(16'h4000, 1'h1, 1'h0);
    // Hide ROM while still in ROM boot: loader flash write refused
    req(5'h01, 8'h98, 1'h1);
    cmd(CMD_FLASH_WRITE, 2'h1);
    cmd(CMD_FLASH_READ, 2'h2);
    req(5'h04, 8'h98, 1'h0);
    req(5'h18, 8'h98, 1'h0);
    req(5'h10, 8'h48, 1'h1);
    for (int k = 0; k < 3; k++) cmd(bmlc_cmd_t'(k), 2'h1);
    req(5'h08, 8'h98, 1'h1);
    req(5'h10, 8'h48, 1'h1);
    req(5'h04, 8'h68, 1'h1);
    req(5'h08, 8'h68, 1'h0);
    cmd(CMD_FLASH_READ, 2'h1);
    cmd(CMD_FLASH_WRITE, 2'h1);
    req(5'h02, 8'h64, 1'h1);
    req(5'h01, 8'h64, 1'h0);
    acc(16'h0000, 1'h0, 1'h1);
    acc(16'h4000, 1'h1, 1'h1);
    acc(16'h4000, 1'h0, 1'h0);
    rst(8'h64);
    req(5'h0A, 8'h64, 1'h0);
    test_done();
  end
endmodule
